// ===== src/urx_defs.svh
// Constants of the receive data recovery block
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH
`define URX_OVERSAMPLE    5'd16
`define URX_TICK_VERIFY_A 5'd3
`define URX_TICK_VERIFY_B 5'd5
`define URX_TICK_VERIFY_C 5'd7
`define URX_TICK_VOTE_A   5'd8
`define URX_TICK_VOTE_B   5'd9
`define URX_TICK_VOTE_C   5'd10
`define URX_BITS_8        4'd8
`define URX_BITS_9        4'd9
`define URX_DATA_RESET    8'h00
`endif

// ===== src/urx_pkg.sv
// Types shared by the receive data recovery block
`default_nettype none
package urx_pkg;
  typedef enum logic [3:0] {
    URX_HUNT   = 4'b0001,
    URX_START  = 4'b0010,
    URX_DATA   = 4'b0100,
    URX_STOP   = 4'b1000
  } urx_state_t;
endpackage
`default_nettype wire

// ===== src/urx_vote_if.sv
// Sample vote bundle between the sampler and the receive controller
`default_nettype none
interface urx_vote_if;
  logic [2:0] samples;
  logic       vote;
  logic       noisy;
  logic       start_ok;
  logic       start_noisy;
  modport voter (input samples, output vote, output noisy, output start_ok,
                 output start_noisy);
  modport user  (output samples, input vote, input noisy, input start_ok,
                 input start_noisy);
endinterface
`default_nettype wire

// ===== src/urx_vote.sv
// Majority vote and start-bit verification of three samples
`default_nettype none
module urx_vote (
  urx_vote_if.voter vif
);
  // Majority of three; noise when they disagree
  assign vif.vote  = (vif.samples[0] & vif.samples[1]) | (vif.samples[1] & vif.samples[2])
                   | (vif.samples[0] & vif.samples[2]);
  assign vif.noisy = ~((&vif.samples) | ~(|vif.samples));
  // Start verified with at most one high sample
  assign vif.start_ok    = ~vif.vote;
  assign vif.start_noisy = ~vif.vote & (|vif.samples);
endmodule
`default_nettype wire

// ===== src/urx_recovery.sv
// Receive data recovery: oversampling, voting, framing and receive buffer
`include "urx_defs.svh"
`default_nettype none
module urx_recovery (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       serial_rx,
  input  wire logic       sample_tick,
  input  wire logic       nine_bit_mode,
  input  wire logic       receive_full_irq_enable,
  input  wire logic       data_read,
  input  wire logic       noise_clear,
  input  wire logic       framing_clear,
  output logic [7:0]      receive_data_buffer,
  output logic            ninth_received_bit,
  output logic            receiver_full_flag,
  output logic            noise_flag,
  output logic            framing_error_flag,
  output logic            rx_irq
);
  urx_pkg::urx_state_t state_q;
  logic       rx_meta_q, rx_sync_q;
  logic [2:0] hist_q;
  logic [4:0] tick_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic [2:0] samp_q;
  logic       prev_bit_q;
  logic       done, noise_ev, frame_ev, edge_seen, last_tick;
  urx_vote_if vif ();
  urx_vote u_vote (.vif(vif));
  assign vif.samples = samp_q;
  assign last_tick = sample_tick & (tick_q == `URX_OVERSAMPLE);
  // Falling edge inside a character after a voted one
  assign edge_seen = sample_tick & prev_bit_q & ~rx_sync_q & hist_q[0]
                     & (state_q == urx_pkg::URX_DATA) & (tick_q > `URX_TICK_VOTE_C);
  assign done = last_tick & (state_q == urx_pkg::URX_STOP);

  // ------------------------------------------------------------
  // Input synchroniser and sample history
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= serial_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // Three previous tick samples for start search
  always_ff @(posedge sys_clk) begin
    if (!rst_n) hist_q <= 3'h0;
    else if (sample_tick) hist_q <= {hist_q[1:0], rx_sync_q};
  end

  // ------------------------------------------------------------
  // Tick counter and state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= urx_pkg::URX_HUNT;
      tick_q  <= 5'h00;
      bit_q   <= 4'h0;
    end else if (sample_tick) begin
      unique case (state_q)
        urx_pkg::URX_HUNT: begin
          if (hist_q == 3'h7 && !rx_sync_q) begin
            state_q <= urx_pkg::URX_START;
            tick_q  <= 5'h01;
          end
        end
        urx_pkg::URX_START: begin
          // Tick 7 sample lands in samp_q on this edge, so judge one tick later
          if (tick_q == `URX_TICK_VOTE_A && !vif.start_ok) begin
            state_q <= urx_pkg::URX_HUNT;
            tick_q  <= 5'h00;
          end else if (tick_q == `URX_OVERSAMPLE) begin
            state_q <= urx_pkg::URX_DATA;
            tick_q  <= 5'h01;
            bit_q   <= 4'h0;
          end else tick_q <= tick_q + 5'h01;
        end
        urx_pkg::URX_DATA: begin
          // An edge opens the next bit early, so the bit count must advance too
          if (edge_seen || tick_q == `URX_OVERSAMPLE) begin
            tick_q <= 5'h01;
            bit_q  <= bit_q + 4'h1;
            if (bit_q + 4'h1 == (nine_bit_mode ? `URX_BITS_9 : `URX_BITS_8))
              state_q <= urx_pkg::URX_STOP;
          end else tick_q <= tick_q + 5'h01;
        end
        urx_pkg::URX_STOP: begin
          // Return to hunt early so a quick next start is not missed
          if (tick_q == `URX_TICK_VOTE_C) begin
            state_q <= urx_pkg::URX_HUNT;
            tick_q  <= 5'h00;
          end else tick_q <= tick_q + 5'h01;
        end
        default: begin
          state_q <= urx_pkg::URX_HUNT;
          tick_q  <= 5'h00;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Vote sampling, shifting and error detection
  // ------------------------------------------------------------
  // Samples collected at 3,5,7 in start and at 8,9,10 in start, data and stop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) samp_q <= 3'h0;
    else if (sample_tick) begin
      if (state_q == urx_pkg::URX_START &&
          (tick_q == `URX_TICK_VERIFY_A || tick_q == `URX_TICK_VERIFY_B ||
           tick_q == `URX_TICK_VERIFY_C))
        samp_q <= {samp_q[1:0], rx_sync_q};
      else if (tick_q == `URX_TICK_VOTE_A || tick_q == `URX_TICK_VOTE_B ||
               tick_q == `URX_TICK_VOTE_C)
        samp_q <= {samp_q[1:0], rx_sync_q};
    end
  end

  // Vote evaluated one clock cycle after the last sample
  logic vote_now_q, verify_now_q;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vote_now_q   <= 1'b0;
      verify_now_q <= 1'b0;
    end else begin
      vote_now_q   <= sample_tick & (tick_q == `URX_TICK_VOTE_C) &
                      (state_q != urx_pkg::URX_HUNT);
      verify_now_q <= sample_tick & (tick_q == `URX_TICK_VERIFY_C) &
                      (state_q == urx_pkg::URX_START);
    end
  end

  // Shift data bits in, track previous voted bit for edge resync
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shift_q    <= 9'h000;
      prev_bit_q <= 1'b0;
    end else if (vote_now_q) begin
      prev_bit_q <= vif.vote;
      if (state_q == urx_pkg::URX_DATA)
        shift_q <= {vif.vote, shift_q[8:1]};
    end
  end

  // Any high at ticks 8, 9, 10 of the start bit counts as noise
  logic vote_noisy;
  assign vote_noisy = (state_q == urx_pkg::URX_START) ? (|samp_q) : vif.noisy;
  assign noise_ev = (verify_now_q & vif.start_noisy) | (vote_now_q & vote_noisy);
  assign frame_ev = vote_now_q & (state_q == urx_pkg::URX_HUNT) & ~vif.vote;

  // ------------------------------------------------------------
  // Buffer and status flags
  // ------------------------------------------------------------
  // Stop vote lands in the same cycle as the return to hunt; commit then
  logic commit;
  assign commit = vote_now_q & (state_q == urx_pkg::URX_HUNT);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      receive_data_buffer <= `URX_DATA_RESET;
      ninth_received_bit  <= 1'b0;
    end else if (commit) begin
      receive_data_buffer <= nine_bit_mode ? shift_q[7:0] : shift_q[8:1];
      ninth_received_bit  <= nine_bit_mode ? shift_q[8] : shift_q[8];
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      receiver_full_flag <= 1'b0;
      noise_flag         <= 1'b0;
      framing_error_flag <= 1'b0;
    end else begin
      receiver_full_flag <= commit | (receiver_full_flag & ~data_read);
      noise_flag         <= noise_ev | (noise_flag & ~noise_clear);
      framing_error_flag <= frame_ev | (framing_error_flag & ~framing_clear);
    end
  end

  // Interrupt from the full flag's next value and enable, so it rises with the flag
  always_ff @(posedge sys_clk) begin
    if (!rst_n) rx_irq <= 1'b0;
    else rx_irq <= (commit | (receiver_full_flag & ~data_read)) & receive_full_irq_enable;
  end
  logic unused_done;
  assign unused_done = done | last_tick;
endmodule
`default_nettype wire

// ===== test/urx_tx_model.sv
// Remote serial transmitter model, LSB first, sixteen ticks a bit
`default_nettype none
module urx_tx_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        sample_tick,
  input  wire logic        go,
  input  wire logic [11:0] frame,
  input  wire logic [3:0]  nbits,
  input  wire logic [7:0]  glitch,
  output logic             busy,
  output logic             serial_rx
);
  logic [11:0] sh_q;
  logic [7:0]  cnt_q;
  logic [3:0]  left_q;
  // Idle high; a glitch inverts one tick so the voter sees noise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      serial_rx <= 1'b1;
    end else if (go) begin
      sh_q <= frame;
      left_q <= nbits;
      cnt_q <= 8'h00;
      busy <= 1'b1;
    end else if (busy && sample_tick) begin
      serial_rx <= sh_q[0] ^ (cnt_q == glitch);
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q[3:0] == 4'hF) begin
        sh_q <= sh_q >> 1;
        left_q <= left_q - 4'h1;
        busy <= left_q != 4'h1;
      end
    end else if (!busy) begin
      serial_rx <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== test/urx_recovery_checker.sv
// Assertions on the receive recovery ports
`default_nettype none
module urx_recovery_checker (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       serial_rx,
  input wire logic       sample_tick,
  input wire logic       nine_bit_mode,
  input wire logic       receive_full_irq_enable,
  input wire logic       data_read,
  input wire logic       noise_clear,
  input wire logic       framing_clear,
  input wire logic [7:0] receive_data_buffer,
  input wire logic       ninth_received_bit,
  input wire logic       receiver_full_flag,
  input wire logic       noise_flag,
  input wire logic       framing_error_flag,
  input wire logic       rx_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // A commit only follows a stop-bit sample tick closely
  sequence s_commit;
    $rose(receiver_full_flag);
  endsequence
  sequence s_recent_tick;
    $past(sample_tick) || $past(sample_tick, 2) || $past(sample_tick, 3) || $past(sample_tick, 4);
  endsequence
  property p_commit_tick;
    s_commit |-> s_recent_tick;
  endproperty
  a_commit_tick: assert property (p_commit_tick) else $error("commit off tick");
  property p_irq_on;
    receiver_full_flag && $past(receive_full_irq_enable) |-> rx_irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off;
    rx_irq |-> receiver_full_flag && $past(receive_full_irq_enable);
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq spurious");
  property p_fe_full;
    $rose(framing_error_flag) |-> receiver_full_flag;
  endproperty
  a_fe_full: assert property (p_fe_full) else $error("framing before full");
  property p_full_hold;
    receiver_full_flag && !data_read |=> receiver_full_flag;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full dropped");
  property p_nf_hold;
    noise_flag && !noise_clear |=> noise_flag;
  endproperty
  a_nf_hold: assert property (p_nf_hold) else $error("noise dropped");
  property p_fe_hold;
    framing_error_flag && !framing_clear |=> framing_error_flag;
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("framing dropped");
  property p_buf_commit;
    $changed(receive_data_buffer) |-> receiver_full_flag;
  endproperty
  a_buf_commit: assert property (p_buf_commit) else $error("buffer moved");
endmodule
`default_nettype wire

// ===== test/urx_recovery_tb.sv
// Self-checking bench for the receive recovery block
`default_nettype none
module urx_recovery_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, rst_n, serial_rx, sample_tick, nine_bit_mode, go, busy;
  logic        receive_full_irq_enable, data_read, noise_clear, framing_clear;
  logic        ninth_received_bit, receiver_full_flag, noise_flag, framing_error_flag, rx_irq;
  logic [7:0]  receive_data_buffer, glitch;
  logic [11:0] frame;
  logic [3:0]  nbits;
  logic [8:0]  v;
  int          bad_count, checks_done, cyc;
  int          exp_q[$];
  urx_recovery uut (.sys_clk, .rst_n, .serial_rx, .sample_tick, .nine_bit_mode,
    .receive_full_irq_enable, .data_read, .noise_clear, .framing_clear, .receive_data_buffer,
    .ninth_received_bit, .receiver_full_flag, .noise_flag, .framing_error_flag, .rx_irq);
  urx_tx_model far (.sys_clk, .rst_n, .sample_tick, .go, .frame, .nbits, .glitch, .busy,
    .serial_rx);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Tick every eighth cycle; the cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    #1;
    cyc++;
    sample_tick = cyc % 8 == 0;
    if (cyc > 40000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One frame from the far side, then flags are checked late and cleared
  task automatic send(input logic stp, input logic fs);
    int n;
    frame = fs ? 12'hFFF : nine_bit_mode ? {1'b1, stp, v, 1'b0} : {2'b11, stp, v[7:0], 1'b0};
    nbits = fs ? 4'h1 : nine_bit_mode ? 4'hB : 4'hA;
    go = 1'b1;
    @(posedge sys_clk);
    #1 go = 1'b0;
    for (n = 0; busy !== 1'b0 && n < 3000; n++) @(posedge sys_clk);
    repeat (40) @(posedge sys_clk);
    #1;
    if (!fs) exp_q.push_back({glitch != 8'hFF, !stp, nine_bit_mode ? v[8] : v[7], v[7:0]});
    if (fs) chk(receiver_full_flag, 16'h0000, "false start");
    else chk({noise_flag, framing_error_flag, ninth_received_bit, receive_data_buffer},
      16'(exp_q.pop_front()), "char");
    chk({receiver_full_flag, rx_irq}, {!fs, !fs && receive_full_irq_enable}, "full");
    {data_read, noise_clear, framing_clear} = 3'h7;
    @(posedge sys_clk);
    #1 {data_read, noise_clear, framing_clear} = 3'h0;
    @(posedge sys_clk);
    #1 chk({receiver_full_flag, noise_flag, framing_error_flag}, 16'h0000, "clear");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Clean, boundary, framing, break, noisy and false-start frames
  initial begin
    void'($urandom(67));
    {rst_n, go, data_read, noise_clear, framing_clear, sample_tick} = 6'h00;
    {nine_bit_mode, receive_full_irq_enable, frame, nbits, glitch} = 26'h00000FF;
    repeat (10) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (40) @(posedge sys_clk);
    #1;
    for (int i = 0; i < 16; i++) begin
      nine_bit_mode = 1'($urandom);
      receive_full_irq_enable = 1'($urandom);
      v = (i == 0 || i == 9) ? 9'h000 : i == 1 ? 9'h1FF : 9'($urandom);
      glitch = i == 10 ? 8'h05 : i == 11 ? 8'h08 : i == 12 ? 8'(16 * (1 + $urandom % 8) + 8)
        : i == 14 ? (nine_bit_mode ? 8'hA8 : 8'h98) : i == 15 ? 8'h00 : 8'hFF;
      send(!(i == 8 || i == 9), i == 15);
    end
    report_and_stop();
  end
endmodule
bind urx_recovery urx_recovery_checker u_chk (.sys_clk, .rst_n, .serial_rx, .sample_tick,
  .nine_bit_mode, .receive_full_irq_enable, .data_read, .noise_clear, .framing_clear,
  .receive_data_buffer, .ninth_received_bit, .receiver_full_flag, .noise_flag,
  .framing_error_flag, .rx_irq);
`default_nettype wire
